// ==== tb/dac_ctrl_test.sv ====
// Self-checking bench for the two channel converter control block
`timescale 1ns/10ps
module dac_ctrl_test;
  import dac_pkg::*;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int     CYC = 8;
  logic              clk;
  logic              rstn;
  logic [ADDR_W-1:0] address;
  logic              read;
  logic              write;
  logic [31:0]       writedata;
  logic [3:0]        byteenable;
  logic [31:0]       readdata;
  logic              waitrequest;
  logic [7:0]        out0;
  logic [7:0]        out1;
  logic              drv0;
  logic              drv1;
  logic              bsy0;
  logic              bsy1;
  logic              set0;
  logic              set1;
  logic [31:0]       q;
  logic              c1;
  logic              c0;
  logic              j;
  int                n_mismatch = 0;
  int                comparisons = 0;

  // Short conversion keeps the run brief
  dac_ctrl #(.CONV_CYCLES(CYC)) dut_u (
    .clk(clk), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .analog_out_ch0(out0), .drive_ch0(drv0), .busy_ch0(bsy0),
    .settled_ch0(set0), .analog_out_ch1(out1), .drive_ch1(drv1),
    .busy_ch1(bsy1), .settled_ch1(set1)
  );

  // Free running clock
  always #10 clk = ~clk;

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus access; entered just after a rising edge
  task automatic bus(input logic is_wr, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    read <= ~is_wr;
    write <= is_wr;
    address <= a;
    writedata <= d;
    byteenable <= be;
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    // Exactly one wait state per access
    check(n, 1);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'h1);
    check(q, exp);
  endtask

  // Single place where the run ends
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  // Main sequence
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = '0;
    writedata = '0;
    byteenable = '0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check({drv1, drv0, bsy1, bsy0, set1, set0}, 0);
    @(posedge clk);
    rd(OFS_CONTROL, 32'h1f);
    rd(OFS_VALUE_CH0, 32'h0);
    rd(OFS_VALUE_CH1, 32'h0);
    $display("test reset done");

    // value registers keep only the low byte
    wr(OFS_VALUE_CH0, 32'hffff_ffa5);
    rd(OFS_VALUE_CH0, 32'ha5);
    wr(OFS_VALUE_CH1, 32'h3c);
    rd(OFS_VALUE_CH1, 32'h3c);
    // Lane 0 disabled, write must not land
    bus(1'b1, OFS_VALUE_CH1, 32'h77, 4'h0);
    rd(OFS_VALUE_CH1, 32'h3c);
    wr(OFS_CONTROL, 32'h00);
    rd(OFS_CONTROL, 32'h1f);
    // Unmapped place reads zero and leaves registers alone
    wr(4'hc, 32'h55);
    rd(4'hc, 32'h0);
    rd(OFS_VALUE_CH0, 32'ha5);
    $display("test registers done");

    // every combination of the three control bits
    for (int m = 0; m < 8; m++) begin
      c1 = m[2];
      c0 = m[1];
      j = m[0];
      wr(OFS_CONTROL, {24'h0, c1, c0, j, 5'h00});
      rd(OFS_CONTROL, {24'h0, c1, c0, j, 5'h1f});
      @(negedge clk);
      check({bsy1, bsy0}, {c1 | j, c0 | j});
      check({drv1, drv0}, {c1, c0});
      check({set1, set0}, 0);
      repeat (CYC + 4) @(posedge clk);
      @(negedge clk);
      check({bsy1, bsy0}, 0);
      check({drv1, drv0}, {c1, c0});
      check({set1, set0}, {c1, c0});
      if (c0 | j)
        check(out0, 8'ha5);
      if (c1 | j)
        check(out1, 8'h3c);
      @(posedge clk);
      wr(OFS_CONTROL, 32'h00);
    end
    $display("test modes done");

    // rewrite restarts, other channel leaves result alone
    wr(OFS_CONTROL, 32'h40);
    repeat (CYC + 4) @(posedge clk);
    wr(OFS_VALUE_CH1, 32'h99);
    @(negedge clk);
    check({set0, out0}, {1'b1, 8'ha5});
    @(posedge clk);
    wr(OFS_VALUE_CH0, 32'h5a);
    @(negedge clk);
    check(bsy0, 1'b1);
    repeat (CYC + 4) @(posedge clk);
    @(negedge clk);
    check({bsy0, set0, out0}, {1'b0, 1'b1, 8'h5a});
    @(posedge clk);
    wr(OFS_CONTROL, 32'h00);
    @(negedge clk);
    check({drv0, set0}, 0);
    $display("test restart done");

    // reset in mid-run turns running channels off
    wr(OFS_CONTROL, 32'he0);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check({drv1, drv0, bsy1, bsy0, set1, set0}, 0);
    @(posedge clk);
    rd(OFS_CONTROL, 32'h1f);
    rd(OFS_VALUE_CH1, 32'h0);
    $display("test mid reset done");
    print_verdict();
  end

  // Watchdog, many times the few hundred cycles the tests need
  initial begin
    repeat (4000) @(posedge clk);
    n_mismatch++;
    $display("BAD t=%0t watchdog expired", $time);
    print_verdict();
  end
endmodule // dac_ctrl_test

// ==== verilog/dac_avs.sv ====
// Avalon-MM handshake helper: one wait cycle per access
`timescale 1ns/10ps
module dac_avs (
  input  wire logic clk,          // Peripheral clock
  input  wire logic rstn,         // Synchronous reset, active low
  input  wire logic read,         // Bus read request
  input  wire logic write,        // Bus write request
  output logic      waitrequest,  // Stall while first cycle
  output logic      accept        // Access completes this edge
);
  import dac_pkg::*;

  typedef struct packed {
    logic ack;
  } dac_avs_s;

  dac_avs_s s;
  dac_avs_s next_s;

  // ------------------------------------------------------------
  // Handshake
  // ------------------------------------------------------------
  // First cycle stalls so read data can be registered
  always_comb begin
    next_s     = s;
    next_s.ack = (read | write) & ~s.ack;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Combinational handshake outputs
  assign waitrequest = (read | write) & ~s.ack;
  assign accept      = (read | write) & s.ack;

  // Request must complete after exactly one wait cycle
  a_wait_one_cycle: assert property (@(posedge clk) disable iff (!rstn)
    ((read | write) && waitrequest) |=> !waitrequest)
    else $error("access not answered after one wait cycle");
endmodule : dac_avs

// ==== verilog/dac_chan.sv ====
// One converter channel: conversion timing and output hold
`timescale 1ns/10ps
module dac_chan #(
  parameter int CONV_CYCLES = dac_pkg::CONV_CYC  // Conversion time
) (
  input  wire logic                   clk,      // Peripheral clock
  input  wire logic                   rstn,     // Sync reset, low
  input  wire logic                   conv_en,  // Conversion enabled
  input  wire logic                   drive_en, // Output drive on
  input  wire logic                   rewrite,  // Value just written
  input  wire logic [dac_pkg::DATA_W-1:0] value, // Value register
  output logic [dac_pkg::DATA_W-1:0]  code,     // Code to converter
  output logic                        drive,    // Analog drive on
  output logic                        busy,     // Converting
  output logic                        settled   // Result presented
);
  import dac_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] code;
    logic [CNT_W-1:0]  cnt;
    logic              busy;
    logic              done;
    logic              en_q;
  } dac_chan_s;

  dac_chan_s s;
  dac_chan_s next_s;
  logic      start;

  // ------------------------------------------------------------
  // Conversion sequencing
  // ------------------------------------------------------------
  // Start on enable rising, or on rewrite while enabled
  assign start = conv_en & (~s.en_q | rewrite);

  // R9 - code held between starts
  always_comb begin
    next_s      = s;
    next_s.en_q = conv_en;
    if (!conv_en) begin
      next_s.busy = 1'b0;
      next_s.done = 1'b0;
    // R8 - restart on rewrite
    end else if (start) begin
      next_s.code = value;
      next_s.busy = 1'b1;
      next_s.done = 1'b0;
      next_s.cnt  = CNT_W'(CONV_CYCLES - 1);
    end else if (s.busy) begin
      if (s.cnt == '0) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end else begin
        next_s.cnt = s.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // R2 - present held code while driven
  assign code    = s.code;
  assign drive   = drive_en;
  assign busy    = s.busy;
  assign settled = s.done & drive_en;

  // Restart loads the full conversion count
  a_start_loads: assert property (@(posedge clk) disable iff (!rstn)
    start |=> busy && s.cnt == CNT_W'(CONV_CYCLES - 1)) // R8
    else $error("conversion did not restart with full count");

  // Code stays put until rewrite or disable
  a_hold_code: assert property (@(posedge clk) disable iff (!rstn)
    (s.done && conv_en && !rewrite) |=> $stable(code)) // R9
    else $error("held output changed without rewrite");
endmodule : dac_chan

// ==== verilog/dac_ctrl.sv ====
// Register side control of the two channel converter
// ------------------------------------------------------------
// Overview of operation
// R1 - Each channel has an 8-bit read/write value register.
// R2 - An enabled channel presents its value to its converter.
// R3 - Control bit 7 enables conversion and drive of channel 1.
// R4 - Control bit 6 enables conversion and drive of channel 0.
// R5 - Control bit 5 makes both channels convert together.
// R6 - Each output is driven only by its own drive enable bit.
// R7 - Control bits 4 to 0 read as ones and ignore writes.
// R8 - Rewriting a converting channel restarts its conversion.
// R9 - A result holds until rewritten or its drive bit clears.
// R10 - Reset leaves both channels off, reserved bits at ones.
// ------------------------------------------------------------
`timescale 1ns/10ps
module dac_ctrl #(
  parameter int CONV_CYCLES = dac_pkg::CONV_CYC  // Conversion time
) (
  input  wire logic                     clk,            // Clock
  input  wire logic                     rstn,           // Reset, low
  input  wire logic [dac_pkg::ADDR_W-1:0] address,      // Byte addr
  input  wire logic                     read,           // Read req
  input  wire logic                     write,          // Write req
  input  wire logic [31:0]              writedata,      // Write data
  input  wire logic [3:0]               byteenable,     // Lanes
  output logic [31:0]                   readdata,       // Read data
  output logic                          waitrequest,    // Stall
  output logic [dac_pkg::DATA_W-1:0]    analog_out_ch0, // Code ch0
  output logic                          drive_ch0,      // Drive ch0
  output logic                          busy_ch0,       // Conv ch0
  output logic                          settled_ch0,    // Result ch0
  output logic [dac_pkg::DATA_W-1:0]    analog_out_ch1, // Code ch1
  output logic                          drive_ch1,      // Drive ch1
  output logic                          busy_ch1,       // Conv ch1
  output logic                          settled_ch1     // Result ch1
);
  import dac_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [DATA_W-1:0] conv_value_ch0;
    logic [DATA_W-1:0] conv_value_ch1;
    logic              ch1_drive_enable;
    logic              ch0_drive_enable;
    logic              joint_conversion_enable;
    logic              rewrite_ch0;
    logic              rewrite_ch1;
    logic [31:0]       rdata;
  } dac_ctrl_s;

  dac_ctrl_s   s;
  dac_ctrl_s   next_s;
  logic        accept;
  logic        wr_low;
  logic        conv_en_ch0;
  logic        conv_en_ch1;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Control byte as software sees it
  function automatic logic [DATA_W-1:0] ctrl_image(
    input logic c1, input logic c0, input logic j);
    // R7 - reserved bits read ones
    ctrl_image = {c1, c0, j, CTRL_RSVD};
  endfunction

  // Read mux, unmapped offsets read zero
  function automatic logic [31:0] read_mux(
    input logic [ADDR_W-1:0] a, input dac_ctrl_s r);
    read_mux = '0;
    unique case (a)
      OFS_VALUE_CH0: read_mux[DATA_W-1:0] = r.conv_value_ch0;
      OFS_VALUE_CH1: read_mux[DATA_W-1:0] = r.conv_value_ch1;
      OFS_CONTROL:   read_mux[DATA_W-1:0] =
        ctrl_image(r.ch1_drive_enable, r.ch0_drive_enable,
                   r.joint_conversion_enable);
      default:       read_mux = '0;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Bus handshake
  // ------------------------------------------------------------
  dac_avs u_avs (
    .clk         (clk),
    .rstn        (rstn),
    .read        (read),
    .write       (write),
    .waitrequest (waitrequest),
    .accept      (accept)
  );

  // Registers live in byte lane 0 only
  assign wr_low = write & accept & byteenable[0];

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  // Read data is captured during the wait cycle so it is a flop
  always_comb begin
    next_s             = s;
    next_s.rewrite_ch0 = 1'b0;
    next_s.rewrite_ch1 = 1'b0;
    if (read && waitrequest) begin
      next_s.rdata = read_mux(address, s);
    end
    if (wr_low) begin
      unique case (address)
        // R1 - value register writes
        OFS_VALUE_CH0: begin
          next_s.conv_value_ch0 = writedata[DATA_W-1:0];
          next_s.rewrite_ch0    = 1'b1;
        end
        OFS_VALUE_CH1: begin
          next_s.conv_value_ch1 = writedata[DATA_W-1:0];
          next_s.rewrite_ch1    = 1'b1;
        end
        // R7 - low five bits not stored
        OFS_CONTROL: begin
          next_s.ch1_drive_enable        = writedata[BIT_CH1_DRIVE];
          next_s.ch0_drive_enable        = writedata[BIT_CH0_DRIVE];
          next_s.joint_conversion_enable = writedata[BIT_JOINT];
        end
        default: begin
          next_s.rewrite_ch0 = 1'b0;
        end
      endcase
    end
  end

  // R10 - reset all channels off
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s                         <= '0;
      s.conv_value_ch0          <= VALUE_RESET;
      s.conv_value_ch1          <= VALUE_RESET;
      s.ch1_drive_enable        <= CTRL_EN_RESET;
      s.ch0_drive_enable        <= CTRL_EN_RESET;
      s.joint_conversion_enable <= CTRL_EN_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign readdata = s.rdata;

  // ------------------------------------------------------------
  // Conversion control
  // ------------------------------------------------------------
  // R3 - bit 7 converts channel 1
  // R5 - joint bit converts both
  assign conv_en_ch1 = s.ch1_drive_enable | s.joint_conversion_enable;
  // R4 - bit 6 converts channel 0
  assign conv_en_ch0 = s.ch0_drive_enable | s.joint_conversion_enable;

  // ------------------------------------------------------------
  // Channels
  // ------------------------------------------------------------
  // R6 - drive follows own bit only
  dac_chan #(
    .CONV_CYCLES (CONV_CYCLES)
  ) u_ch0 (
    .clk      (clk),
    .rstn     (rstn),
    .conv_en  (conv_en_ch0),
    .drive_en (s.ch0_drive_enable),
    .rewrite  (s.rewrite_ch0),
    .value    (s.conv_value_ch0),
    .code     (analog_out_ch0),
    .drive    (drive_ch0),
    .busy     (busy_ch0),
    .settled  (settled_ch0)
  );

  // Rewrite pulse lags the write by one edge so value is stable
  dac_chan #(
    .CONV_CYCLES (CONV_CYCLES)
  ) u_ch1 (
    .clk      (clk),
    .rstn     (rstn),
    .conv_en  (conv_en_ch1),
    .drive_en (s.ch1_drive_enable),
    .rewrite  (s.rewrite_ch1),
    .value    (s.conv_value_ch1),
    .code     (analog_out_ch1),
    .drive    (drive_ch1),
    .busy     (busy_ch1),
    .settled  (settled_ch1)
  );

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // Accepted value write shows up on the next read of it
  a_value_write: assert property (@(posedge clk) disable iff (!rstn)
    (wr_low && address == OFS_VALUE_CH0)
    |=> s.conv_value_ch0 == $past(writedata[DATA_W-1:0])) // R1
    else $error("channel 0 value write lost");

  // Channel 1 value write lands as well
  a_value_write1: assert property (@(posedge clk) disable iff (!rstn)
    (wr_low && address == OFS_VALUE_CH1)
    |=> s.conv_value_ch1 == $past(writedata[DATA_W-1:0])) // R1
    else $error("channel 1 value write lost");

  // Masked lane leaves both value registers and the bit 6 enable alone
  a_lane_masked: assert property (@(posedge clk) disable iff (!rstn)
    (write && accept && !byteenable[0])
    |=> $stable(s.conv_value_ch0) && $stable(s.conv_value_ch1)
        && $stable(s.ch0_drive_enable)) // R1
    else $error("write with lane 0 off changed a register");

  // Value read returns the register in lane 0
  a_value_read: assert property (@(posedge clk) disable iff (!rstn)
    (read && waitrequest && address == OFS_VALUE_CH0)
    |=> readdata == {24'h0, $past(s.conv_value_ch0)}) // R1
    else $error("channel 0 value read wrong");

  // Settled channel presents its value register
  a_present_value: assert property (@(posedge clk) disable iff (!rstn)
    (settled_ch1 && !s.rewrite_ch1 && !busy_ch1)
    |-> analog_out_ch1 == s.conv_value_ch1) // R2
    else $error("channel 1 code differs from value register");

  // Channel 0 likewise presents its value register
  a_present_ch0: assert property (@(posedge clk) disable iff (!rstn)
    (settled_ch0 && !s.rewrite_ch0 && !busy_ch0)
    |-> analog_out_ch0 == s.conv_value_ch0) // R2
    else $error("channel 0 code differs from value register");

  // Bit 7 alone starts channel 1 and drives it
  a_ch1_enable: assert property (@(posedge clk) disable iff (!rstn)
    $rose(conv_en_ch1) && !s.joint_conversion_enable
    |=> busy_ch1 && drive_ch1) // R3
    else $error("channel 1 did not start on enable");

  // Bit 6 alone starts channel 0 and drives it
  a_ch0_enable: assert property (@(posedge clk) disable iff (!rstn)
    $rose(conv_en_ch0) && !s.joint_conversion_enable
    |=> busy_ch0 && drive_ch0) // R4
    else $error("channel 0 did not start on enable");

  // Bit 6 cleared removes channel 0 drive at once
  a_ch0_disable: assert property (@(posedge clk) disable iff (!rstn)
    !s.ch0_drive_enable |-> !drive_ch0 && !settled_ch0) // R4
    else $error("channel 0 driven while disabled");

  // Bit 7 cleared removes channel 1 drive at once
  a_ch1_disable: assert property (@(posedge clk) disable iff (!rstn)
    !s.ch1_drive_enable |-> !drive_ch1 && !settled_ch1) // R3
    else $error("channel 1 driven while disabled");

  // Joint bit converts both without drive
  a_joint_both: assert property (@(posedge clk) disable iff (!rstn)
    $rose(conv_en_ch0) && $rose(conv_en_ch1) && !s.ch0_drive_enable
    && !s.ch1_drive_enable
    |=> busy_ch0 && busy_ch1 && !drive_ch0 && !drive_ch1) // R5
    else $error("joint conversion misbehaved");

  // Joint conversion never drives channel 1 while bit 7 is clear
  a_drive_own_bit: assert property (@(posedge clk) disable iff (!rstn)
    (s.joint_conversion_enable && !s.ch1_drive_enable)
    |-> !drive_ch1 && !settled_ch1) // R6
    else $error("channel 1 driven by joint bit");

  // Joint conversion never drives channel 0 either
  a_drive_own0: assert property (@(posedge clk) disable iff (!rstn)
    (s.joint_conversion_enable && !s.ch0_drive_enable)
    |-> !drive_ch0 && !settled_ch0) // R6
    else $error("channel 0 driven by joint bit");

  // Control read returns ones in the reserved bits
  a_rsvd_ones: assert property (@(posedge clk) disable iff (!rstn)
    (read && waitrequest && address == OFS_CONTROL)
    |=> readdata[4:0] == CTRL_RSVD && readdata[31:8] == '0) // R7
    else $error("reserved control bits not read as ones");

  // Control write stores bits 7 to 5 only
  a_ctrl_write: assert property (@(posedge clk) disable iff (!rstn)
    (wr_low && address == OFS_CONTROL)
    |=> {s.ch1_drive_enable, s.ch0_drive_enable, s.joint_conversion_enable}
        == $past(writedata[BIT_CH1_DRIVE:BIT_JOINT])) // R3
    else $error("control write stored wrongly");

  // Value rewrite while converting restarts the channel
  a_rewrite_restart: assert property (@(posedge clk) disable iff (!rstn)
    (wr_low && address == OFS_VALUE_CH0 && conv_en_ch0
     && !(write && address == OFS_CONTROL))
    |=> ##1 busy_ch0 && !settled_ch0) // R8
    else $error("rewrite did not restart channel 0");

  // Value rewrite restarts channel 1 as well
  a_rewrite_ch1: assert property (@(posedge clk) disable iff (!rstn)
    (wr_low && address == OFS_VALUE_CH1 && conv_en_ch1)
    |=> ##1 busy_ch1 && !settled_ch1) // R8
    else $error("rewrite did not restart channel 1");

  // Settled result holds while nothing changes
  a_result_hold: assert property (@(posedge clk) disable iff (!rstn)
    (settled_ch0 && !s.rewrite_ch0 && !wr_low)
    |=> settled_ch0 && $stable(analog_out_ch0)) // R9
    else $error("channel 0 result dropped");

  // Clearing the enable ends conversion and result
  a_disable_stop: assert property (@(posedge clk) disable iff (!rstn)
    $fell(conv_en_ch1) |=> !busy_ch1 && !settled_ch1) // R9
    else $error("channel 1 kept running after disable");

  // Out of reset nothing converts or drives
  a_reset_off: assert property (@(posedge clk)
    !rstn |=> !drive_ch0 && !drive_ch1 && !busy_ch0 && !busy_ch1) // R10
    else $error("channel active after reset");
endmodule : dac_ctrl

// ==== verilog/dac_pkg.sv ====
// Shared constants for the dual channel converter control block
package dac_pkg;
  // ------------------------------------------------------------
  // Register map (byte addresses on the bus)
  // ------------------------------------------------------------
  localparam int          ADDR_W       = 4;
  localparam logic [3:0]  OFS_VALUE_CH0 = 4'h0;
  localparam logic [3:0]  OFS_VALUE_CH1 = 4'h4;
  localparam logic [3:0]  OFS_CONTROL   = 4'h8;

  // ------------------------------------------------------------
  // Field layout and reset values
  // ------------------------------------------------------------
  localparam int          DATA_W        = 8;
  localparam int          BIT_CH1_DRIVE = 7;
  localparam int          BIT_CH0_DRIVE = 6;
  localparam int          BIT_JOINT     = 5;
  localparam logic [4:0]  CTRL_RSVD     = 5'h1f;
  localparam logic [7:0]  VALUE_RESET   = 8'h00;
  localparam logic        CTRL_EN_RESET = 1'h0;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 20;
  localparam int          T_CONV_NS     = 10000;
  // Longest conversion time rounds down to whole cycles
  localparam int          CONV_CYC      = T_CONV_NS / CLK_PERIOD_NS;
  localparam int          CNT_W         = 9;
endpackage : dac_pkg
